// *** hdl/irct_timer.sv ***
// irct_timer: 12-bit ir carrier timer with carrier pwm, level pwm,
// carrier period capture and envelope detect, apb register slave.
// assumes rx_in and companion inputs are synchronous to pclk.
//
// Functional notes
// - clock select: full, half, quarter, sixteenth rate
// - start loads preload (zero in capture and envelope modes), then counts upward
// - pwm overflow reloads preload and continues
// - duty select: third, quarter, fifth, half
// - mode select: carrier, level, capture, envelope
// - entering level mode drives output high
// - control bit seven enables the timer
// - free-running companion: enable bit gates carrier
// - carrier-clocked companion: overflow toggles envelope
// - level mode never puts carrier on pin
// - config bit six low enables pwm output
// - capture copies count, flags, clears counter
// - control bit six picks capture edge
// - capture mode overflow raises overflow flag
// - config bit five picks unmodulated envelope input
// - first carrier edge flags, presents, loads reload
// - further edges reload, presence stays set
// - overflow without edge flags and clears presence
// - unmodulated input level drives presence directly
// - count low reads live, writes preload
// - capture high reads, envelope high writes
// - companion select three uses our carrier
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps

module irct_timer
    import irct_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              rx_in,
    input  wire logic [1:0]        companion_clock_select,
    input  wire logic              companion_overflow_event,
    output logic                   carrier_clock_source,
    output logic                   ir_transmit_pin
);

    if (ADDR_W < 10) begin : g_addr_check
        $error("irct_timer: ADDR_W must be at least 10");
    end

    logic [7:0]        control_reg;
    logic [7:0]        special_cfg_reg;
    logic [CNT_W-1:0]  preload_reg;
    logic [CNT_W-1:0]  env_reload_reg;
    logic [CNT_W-1:0]  capture_reg;
    logic [CNT_W-1:0]  cnt_reg;
    logic [CNT_W-1:0]  cnt_next;
    logic [3:0]        pre_reg;
    logic [2:0]        phase_reg;
    logic [2:0]        phase_next;
    logic              rx_prev_reg;
    logic              present_reg;
    logic              present_next;
    logic              env_tog_reg;
    logic              ovf_if_reg;
    logic              cap_if_reg;
    logic              env_if_reg;
    logic              pin_reg;
    logic              carrier_reg;
    logic [31:0]       prdata_reg;

    // apb decode
    wire [9:0] addr_lo   = paddr[9:0];
    wire       addr_hi_z = (paddr[ADDR_W-1:2] >> 8) == '0;
    wire       hit_status  = addr_hi_z && addr_lo == {IDX_STATUS, 2'b00};
    wire       hit_special = addr_hi_z && addr_lo == {IDX_SPECIAL_CFG, 2'b00};
    wire       hit_control = addr_hi_z && addr_lo == {IDX_CONTROL, 2'b00};
    wire       hit_cnt_lo  = addr_hi_z && addr_lo == {IDX_COUNT_LOW, 2'b00};
    wire       hit_cap_hi  = addr_hi_z && addr_lo == {IDX_CAPTURE_HIGH, 2'b00};
    wire       hit_env_hi  = addr_hi_z && addr_lo == {IDX_ENVELOPE_HI, 2'b00};
    wire       hit_cnt_hi  = addr_hi_z && addr_lo == {IDX_COUNT_HIGH, 2'b00};
    wire       hit_cap_lo  = addr_hi_z && addr_lo == {IDX_CAPTURE_LOW, 2'b00};
    wire       hit_env_lo  = addr_hi_z && addr_lo == {IDX_ENVELOPE_LOW, 2'b00};
    wire       mapped      = hit_status | hit_special | hit_control | hit_cnt_lo |
                             hit_cap_hi | hit_cnt_hi | hit_cap_lo | hit_env_lo;
    wire       acc_phase   = psel && penable;
    wire       wr_en       = acc_phase && pwrite && mapped;
    wire       rd_setup    = psel && !penable && !pwrite;

    // control fields
    wire       enable     = control_reg[CTRL_ENABLE_BIT];
    wire       edge_fall  = control_reg[CTRL_EDGE_BIT];
    wire [1:0] clk_sel    = control_reg[CTRL_CLK_LSB +: 2];
    wire [1:0] duty_sel   = control_reg[CTRL_DUTY_LSB +: 2];
    wire [1:0] mode       = control_reg[CTRL_MODE_LSB +: 2];
    wire       pwm_dis    = special_cfg_reg[CFG_PWM_DIS_BIT];
    wire       unmod      = special_cfg_reg[CFG_UNMOD_BIT];
    wire [7:0] wbyte      = pwdata[7:0];
    wire [1:0] new_mode   = wbyte[CTRL_MODE_LSB +: 2];
    wire       ctrl_wr    = wr_en && hit_control;

    // a start, or a mode change while running, reinitialises the counter
    wire       restart    = ctrl_wr && wbyte[CTRL_ENABLE_BIT] &&
                            (!enable || new_mode != mode);
    wire       enter_lvl  = ctrl_wr && new_mode == MODE_PWM_LEVEL &&
                            mode != MODE_PWM_LEVEL;

    // prescaler tick
    wire tick = (clk_sel == CLK_DIV1) ? 1'b1 :
                (clk_sel == CLK_DIV2) ? (pre_reg & MASK_DIV2) == MASK_DIV2 :
                (clk_sel == CLK_DIV4) ? (pre_reg & MASK_DIV4) == MASK_DIV4 :
                                        (pre_reg & MASK_DIV16) == MASK_DIV16;

    // receive edges
    wire rx_rise  = rx_in && !rx_prev_reg;
    wire rx_fall  = !rx_in && rx_prev_reg;
    wire sel_edge = edge_fall ? rx_fall : rx_rise;

    wire run      = enable && !restart;
    wire pwm_mode = !mode[1];
    wire cap_mode = mode == MODE_CAPTURE;
    wire env_car  = mode == MODE_ENVELOPE && !unmod;
    wire at_max   = cnt_reg == CNT_MAX;

    // overflow only counts where the counter actually advances
    wire ovf_evt  = run && tick && at_max &&
                    (pwm_mode || (cap_mode && !sel_edge) ||
                     (env_car && present_reg && !sel_edge));
    wire cap_evt  = run && cap_mode && sel_edge;
    wire env_evt  = run && env_car &&
                    ((sel_edge && !present_reg) || ovf_evt);

    // duty segments per carrier period
    wire [2:0] seg_cnt = (duty_sel == DUTY_THIRD)   ? SEG_THIRD :
                         (duty_sel == DUTY_QUARTER) ? SEG_QUARTER :
                         (duty_sel == DUTY_FIFTH)   ? SEG_FIFTH : SEG_HALF;

    // carrier is high during one overflow segment of each period
    wire carrier  = enable && pwm_mode && phase_reg == 3'h0;

    // envelope gate: enable bit, or companion overflows when it runs on carrier
    wire comp_on_carrier = companion_clock_select == COMP_CLK_CARRIER;
    wire env_on   = comp_on_carrier ? env_tog_reg : enable;
    wire out_act  = enable && !pwm_dis && pwm_mode;
    wire pin_next = out_act && env_on &&
                    (mode == MODE_PWM_CARRIER ? carrier : 1'b1);

    always_comb begin
        cnt_next = cnt_reg;
        if (restart) begin
            if (new_mode == MODE_CAPTURE || new_mode == MODE_ENVELOPE) begin
                cnt_next = CNT_ZERO;
            end else begin
                cnt_next = preload_reg;
            end
        end else if (enable) begin
            case (mode)
                MODE_PWM_CARRIER, MODE_PWM_LEVEL: begin
                    if (tick) begin
                        // preload is sampled only here and at restart, so writes wait
                        cnt_next = at_max ? preload_reg : cnt_reg + 12'h001;
                    end
                end
                MODE_CAPTURE: begin
                    if (sel_edge) begin
                        cnt_next = CNT_ZERO;
                    end else if (tick) begin
                        cnt_next = cnt_reg + 12'h001;
                    end
                end
                MODE_ENVELOPE: begin
                    if (!unmod && sel_edge) begin
                        cnt_next = env_reload_reg;
                    end else if (!unmod && tick && present_reg) begin
                        cnt_next = cnt_reg + 12'h001;
                    end
                end
                default: cnt_next = cnt_reg;
            endcase
        end
    end

    always_comb begin
        phase_next = phase_reg;
        if (restart) begin
            phase_next = 3'h0;
        end else if (ovf_evt && pwm_mode) begin
            phase_next = (phase_reg >= seg_cnt - 3'h1) ? 3'h0 : phase_reg + 3'h1;
        end
    end

    always_comb begin
        present_next = present_reg;
        if (enable && mode == MODE_ENVELOPE && unmod) begin
            present_next = rx_in;
        end else if (restart && new_mode == MODE_ENVELOPE) begin
            present_next = 1'b0;
        end else if (run && env_car && sel_edge) begin
            present_next = 1'b1;
        end else if (run && env_car && ovf_evt) begin
            present_next = 1'b0;
        end
    end

    // apb read mux, sampled in setup phase so pready can stay high
    wire [31:0] rd_mux =
        hit_status  ? {24'h0, present_reg, 4'h0, env_if_reg, cap_if_reg, ovf_if_reg} :
        hit_special ? {24'h0, special_cfg_reg} :
        hit_control ? {24'h0, control_reg} :
        hit_cnt_lo  ? {24'h0, cnt_reg[7:0]} :
        hit_cap_hi  ? {28'h0, capture_reg[11:8]} :
        hit_cnt_hi  ? {28'h0, cnt_reg[11:8]} :
        hit_cap_lo  ? {24'h0, capture_reg[7:0]} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg     <= CONTROL_RST;
            special_cfg_reg <= SPECIAL_CFG_RST;
            preload_reg     <= PRELOAD_RST;
            env_reload_reg  <= ENV_RELOAD_RST;
            prdata_reg      <= 32'h0;
        end else begin
            if (ctrl_wr) begin
                control_reg <= wbyte;
            end
            if (wr_en && hit_special) begin
                special_cfg_reg <= wbyte & 8'h60;
            end
            if (wr_en && hit_cnt_lo) begin
                preload_reg[7:0] <= wbyte;
            end
            if (wr_en && hit_cnt_hi) begin
                preload_reg[11:8] <= wbyte[3:0];
            end
            if (wr_en && hit_env_hi) begin
                env_reload_reg[11:8] <= wbyte[3:0];
            end
            if (wr_en && hit_env_lo) begin
                env_reload_reg[7:0] <= wbyte;
            end
            if (rd_setup) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg     <= CNT_ZERO;
            pre_reg     <= 4'h0;
            phase_reg   <= 3'h0;
            rx_prev_reg <= 1'b0;
            present_reg <= 1'b0;
            capture_reg <= CAPTURE_RST;
        end else begin
            cnt_reg     <= cnt_next;
            pre_reg     <= (restart || !enable) ? 4'h0 : pre_reg + 4'h1;
            phase_reg   <= phase_next;
            rx_prev_reg <= rx_in;
            present_reg <= present_next;
            if (cap_evt) begin
                capture_reg <= cnt_reg;
            end
        end
    end

    // sticky flags, write one to clear; a set in the same cycle wins
    wire [7:0] w1c = (wr_en && hit_status) ? wbyte : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_if_reg <= 1'b0;
            cap_if_reg <= 1'b0;
            env_if_reg <= 1'b0;
        end else begin
            ovf_if_reg <= ovf_evt || (ovf_if_reg && !w1c[ST_OVF_IF_BIT]);
            cap_if_reg <= cap_evt || (cap_if_reg && !w1c[ST_CAP_IF_BIT]);
            env_if_reg <= env_evt || (env_if_reg && !w1c[ST_ENV_IF_BIT]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            env_tog_reg <= 1'b0;
            pin_reg     <= 1'b0;
            carrier_reg <= 1'b0;
        end else begin
            if (restart || enter_lvl) begin
                env_tog_reg <= 1'b1;
            end else if (comp_on_carrier && companion_overflow_event) begin
                env_tog_reg <= !env_tog_reg;
            end
            pin_reg     <= pin_next;
            carrier_reg <= carrier;
        end
    end

    assign prdata               = prdata_reg;
    assign pready               = 1'b1;
    assign pslverr              = acc_phase && !mapped;
    assign ir_transmit_pin      = pin_reg;
    assign carrier_clock_source = carrier_reg;

    // checks
    AST_CAP_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        cap_evt |=> cnt_reg == CNT_ZERO && cap_if_reg && capture_reg == $past(cnt_reg))
        else $error("capture did not copy and clear counter");

    AST_PWM_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
        run && pwm_mode && tick && at_max |=> cnt_reg == $past(preload_reg))
        else $error("pwm overflow did not reload preload");

    AST_START_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        restart && !new_mode[1] |=> cnt_reg == $past(preload_reg) && enable)
        else $error("start did not load preload");

    AST_OUT_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        (!enable || pwm_dis) |=> !ir_transmit_pin)
        else $error("output active while disabled");

    AST_DIV2: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && clk_sel == CLK_DIV2 && !restart) ##1 (clk_sel == CLK_DIV2) |-> !tick)
        else $error("half rate tick came too soon");

    AST_LEVEL_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_PWM_LEVEL && $past(mode) != MODE_PWM_LEVEL) |-> env_tog_reg)
        else $error("level mode entry did not set output high");

    AST_ENV_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
        run && env_car && sel_edge && !present_reg
        |=> present_reg && env_if_reg && cnt_reg == $past(env_reload_reg))
        else $error("first carrier edge not handled");

    AST_ENV_LOSS: assert property (@(posedge pclk) disable iff (!presetn)
        run && env_car && present_reg && tick && at_max && !sel_edge
        |=> !present_reg && env_if_reg)
        else $error("carrier loss not flagged");

    AST_UNMOD: assert property (@(posedge pclk) disable iff (!presetn)
        enable && mode == MODE_ENVELOPE && unmod |=> present_reg == $past(rx_in))
        else $error("unmodulated level not passed to presence");

    AST_LEVEL_NO_CARRIER: assert property (@(posedge pclk) disable iff (!presetn)
        out_act && mode == MODE_PWM_LEVEL |=> ir_transmit_pin == $past(env_on))
        else $error("carrier leaked in level mode");

    AST_CAP_OVF: assert property (@(posedge pclk) disable iff (!presetn)
        run && cap_mode && tick && at_max && !sel_edge |=> ovf_if_reg)
        else $error("capture overflow not flagged");

    AST_ENV_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
        run && env_car && sel_edge && present_reg
        |=> present_reg && cnt_reg == $past(env_reload_reg))
        else $error("further carrier edge did not reload");

    COV_CAPTURE: cover property (@(posedge pclk) disable iff (!presetn) cap_evt);
    COV_ENV_CYCLE: cover property (@(posedge pclk) disable iff (!presetn)
        env_evt && !present_reg ##[1:200] env_evt && present_reg);
    COV_CARRIER_OUT: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(ir_transmit_pin) && mode == MODE_PWM_CARRIER);
    COV_COMP_TOGGLE: cover property (@(posedge pclk) disable iff (!presetn)
        comp_on_carrier && companion_overflow_event && out_act);

endmodule : irct_timer

// *** hdl/irct_pkg.sv ***
// irct_pkg: register map, field layout, reset values and codes of the
// ir carrier timer. assumes 32-bit apb words, one register per word.
package irct_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS       = 8'h16;
    localparam logic [7:0] IDX_SPECIAL_CFG  = 8'h17;
    localparam logic [7:0] IDX_CONTROL      = 8'h21;
    localparam logic [7:0] IDX_COUNT_LOW    = 8'h23;
    localparam logic [7:0] IDX_CAPTURE_HIGH = 8'h24;
    localparam logic [7:0] IDX_ENVELOPE_HI  = 8'h24;
    localparam logic [7:0] IDX_COUNT_HIGH   = 8'h28;
    localparam logic [7:0] IDX_CAPTURE_LOW  = 8'h29;
    localparam logic [7:0] IDX_ENVELOPE_LOW = 8'h2a;

    // control register fields
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int CTRL_EDGE_BIT   = 6;
    localparam int CTRL_CLK_LSB    = 4;
    localparam int CTRL_DUTY_LSB   = 2;
    localparam int CTRL_MODE_LSB   = 0;

    // special configuration fields
    localparam int CFG_PWM_DIS_BIT = 6;
    localparam int CFG_UNMOD_BIT   = 5;

    // status fields
    localparam int ST_PRESENT_BIT  = 7;
    localparam int ST_ENV_IF_BIT   = 2;
    localparam int ST_CAP_IF_BIT   = 1;
    localparam int ST_OVF_IF_BIT   = 0;

    // reset values
    localparam logic [7:0]  CONTROL_RST     = 8'h00;
    localparam logic [7:0]  SPECIAL_CFG_RST = 8'h00;
    localparam logic [11:0] PRELOAD_RST     = 12'h000;
    localparam logic [11:0] ENV_RELOAD_RST  = 12'h000;
    localparam logic [11:0] CAPTURE_RST     = 12'h000;

    // counter
    localparam int          CNT_W   = 12;
    localparam logic [11:0] CNT_MAX = 12'hfff;
    localparam logic [11:0] CNT_ZERO = 12'h000;

    // operating modes
    localparam logic [1:0] MODE_PWM_CARRIER = 2'b00;
    localparam logic [1:0] MODE_PWM_LEVEL   = 2'b01;
    localparam logic [1:0] MODE_CAPTURE     = 2'b10;
    localparam logic [1:0] MODE_ENVELOPE    = 2'b11;

    // timer clock select and prescaler masks
    localparam logic [1:0] CLK_DIV1  = 2'b00;
    localparam logic [1:0] CLK_DIV2  = 2'b01;
    localparam logic [1:0] CLK_DIV4  = 2'b10;
    localparam logic [3:0] MASK_DIV2 = 4'h1;
    localparam logic [3:0] MASK_DIV4 = 4'h3;
    localparam logic [3:0] MASK_DIV16 = 4'hf;

    // duty select: number of overflow segments per carrier period
    localparam logic [1:0] DUTY_THIRD   = 2'b00;
    localparam logic [1:0] DUTY_QUARTER = 2'b01;
    localparam logic [1:0] DUTY_FIFTH   = 2'b10;
    localparam logic [2:0] SEG_THIRD    = 3'h3;
    localparam logic [2:0] SEG_QUARTER  = 3'h4;
    localparam logic [2:0] SEG_FIFTH    = 3'h5;
    localparam logic [2:0] SEG_HALF     = 3'h2;

    // companion clock select code that picks our carrier
    localparam logic [1:0] COMP_CLK_CARRIER = 2'b11;

endpackage : irct_pkg

// *** sim/irct_ir_front.sv ***
// irct_ir_front: behavioural ir receiver front end facing the timer pin.
// assumes the bench requests a carrier burst or a steady level on rx.
`timescale 1ns/1ps

module irct_ir_front (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       carrier_on,
    input  wire logic       steady_level,
    input  wire logic [7:0] half_period,
    output logic            rx_in
);
    logic [7:0] phase_reg;
    logic       wave_reg;

    // receiver output rests low between frames, as its pull-down would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= 8'h00;
            wave_reg  <= 1'b0;
        end else if (!carrier_on) begin
            phase_reg <= 8'h00;
            wave_reg  <= 1'b0;
        end else if (phase_reg == half_period - 8'h01) begin
            phase_reg <= 8'h00;
            wave_reg  <= ~wave_reg;
        end else begin
            phase_reg <= phase_reg + 8'h01;
        end
    end

    assign rx_in = (carrier_on & wave_reg) | steady_level;
endmodule : irct_ir_front

// *** sim/ir_carrier_timer_capture_envelope_tb.sv ***
// bench for irct_timer: apb register access, carrier pwm, capture, envelope.
// assumes a 100 MHz pclk and a behavioural receiver on rx_in.
`timescale 1ns/1ps

module ir_carrier_timer_capture_envelope_tb;
    import irct_pkg::*;
    logic        pclk       = 1'b0;
    logic        presetn    = 1'b0;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [9:0]  paddr      = 10'h000;
    logic [31:0] pwdata     = 32'h0;
    logic [1:0]  comp_sel   = 2'b00;
    logic        comp_ovf   = 1'b0;
    logic        rx_carrier = 1'b0;
    logic        rx_level   = 1'b0;
    logic [7:0]  rx_half    = 8'h04;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_in;
    logic        tx_pin;
    logic        car_src;
    logic [31:0] rd;
    logic        rerr;
    int          err_count  = 0;
    int          cmp_count  = 0;

    always #5 pclk = ~pclk;

    irct_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_in(rx_in), .companion_clock_select(comp_sel),
        .companion_overflow_event(comp_ovf), .carrier_clock_source(car_src),
        .ir_transmit_pin(tx_pin));
    irct_ir_front front (.pclk(pclk), .presetn(presetn), .carrier_on(rx_carrier),
        .steady_level(rx_level), .half_period(rx_half), .rx_in(rx_in));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // setup then access; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cycles(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : cycles

    task automatic wait_pin(input logic v);
        int n;
        n = 0;
        while (tx_pin !== v && n < 300) begin
            cycles(1);
            n++;
        end
    endtask : wait_pin

    // skips one whole period so restart transients are not measured
    task automatic measure(output int hi, output int per);
        wait_pin(1'b0);
        wait_pin(1'b1);
        wait_pin(1'b0);
        wait_pin(1'b1);
        hi = 0;
        per = 0;
        while (tx_pin === 1'b1 && per < 300) begin
            cycles(1);
            hi++;
            per++;
        end
        while (tx_pin === 1'b0 && per < 300) begin
            cycles(1);
            per++;
        end
    endtask : measure

    task automatic pulse_companion();
        @(posedge pclk);
        comp_ovf <= 1'b1;
        @(posedge pclk);
        comp_ovf <= 1'b0;
        cycles(3);
    endtask : pulse_companion

    task automatic t_reset();
        apb(1'b0, IDX_CONTROL, 8'h00);
        check("control reset", rd, 32'h0);
        apb(1'b0, IDX_SPECIAL_CFG, 8'h00);
        check("special config reset", rd, 32'h0);
        apb(1'b0, IDX_COUNT_LOW, 8'h00);
        check("count low reset", rd, 32'h0);
        apb(1'b1, IDX_CAPTURE_LOW, 8'h5a);
        apb(1'b0, IDX_CAPTURE_LOW, 8'h00);
        check("capture low ignores write", rd, 32'h0);
        apb(1'b0, 8'h30, 8'h00);
        check("unmapped error", {31'h0, rerr}, 32'h1);
        $display("register reset test done");
    endtask : t_reset

    task automatic t_pwm();
        int hi;
        int per;
        int segs [4] = '{3, 4, 5, 2};
        int divs [4] = '{1, 2, 4, 16};
        apb(1'b1, IDX_COUNT_LOW, 8'hfe);
        apb(1'b1, IDX_COUNT_HIGH, 8'h0f);
        for (int d = 0; d < 4; d++) begin
            apb(1'b1, IDX_CONTROL, 8'h80 | 8'(d << 2));
            measure(hi, per);
            check("carrier high time", 32'(hi), 32'd2);
            check("carrier period", 32'(per), 32'(2 * segs[d]));
        end
        apb(1'b1, IDX_COUNT_LOW, 8'hff);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, IDX_CONTROL, 8'h8c | 8'(c << 4));
            measure(hi, per);
            check("divided high time", 32'(hi), 32'(divs[c]));
            check("divided period", 32'(per), 32'(2 * divs[c]));
        end
        $display("carrier pwm test done");
    endtask : t_pwm

    task automatic t_level();
        int n;
        int m;
        @(posedge pclk);
        comp_sel <= 2'b11;
        apb(1'b1, IDX_CONTROL, 8'h81);
        cycles(3);
        n = 0;
        m = 0;
        repeat (30) begin
            cycles(1);
            n += (tx_pin === 1'b1) ? 1 : 0;
            m += (car_src === 1'b1) ? 1 : 0;
        end
        check("level mode steady high", 32'(n), 32'd30);
        check("carrier runs in level mode", 32'(m), 32'd10);
        pulse_companion();
        check("companion toggles off", {31'h0, tx_pin}, 32'h0);
        pulse_companion();
        check("companion toggles on", {31'h0, tx_pin}, 32'h1);
        @(posedge pclk);
        comp_sel <= 2'b00;
        pulse_companion();
        check("enable bit gates output", {31'h0, tx_pin}, 32'h1);
        apb(1'b1, IDX_SPECIAL_CFG, 8'h40);
        cycles(3);
        check("output disabled rests low", {31'h0, tx_pin}, 32'h0);
        apb(1'b1, IDX_SPECIAL_CFG, 8'h00);
        apb(1'b1, IDX_CONTROL, 8'h01);
        cycles(3);
        check("timer disabled rests low", {31'h0, tx_pin}, 32'h0);
        $display("level and companion test done");
    endtask : t_level

    task automatic t_capture();
        apb(1'b1, IDX_CONTROL, 8'h82);
        @(posedge pclk);
        rx_half    <= 8'd10;
        rx_carrier <= 1'b1;
        cycles(60);
        apb(1'b0, IDX_STATUS, 8'h00);
        check("capture flag", rd & 32'h2, 32'h2);
        apb(1'b0, IDX_CAPTURE_LOW, 8'h00);
        check("captured low byte", rd, 32'h13);
        apb(1'b0, IDX_CAPTURE_HIGH, 8'h00);
        check("captured high nibble", rd, 32'h0);
        @(posedge pclk);
        rx_carrier <= 1'b0;
        apb(1'b1, IDX_CONTROL, 8'hc2);
        apb(1'b1, IDX_STATUS, 8'h07);
        @(posedge pclk);
        rx_level <= 1'b1;
        cycles(5);
        apb(1'b0, IDX_STATUS, 8'h00);
        check("rising edge ignored", rd & 32'h2, 32'h0);
        @(posedge pclk);
        rx_level <= 1'b0;
        cycles(5);
        apb(1'b0, IDX_STATUS, 8'h00);
        check("falling edge captured", rd & 32'h2, 32'h2);
        cycles(4200);
        apb(1'b0, IDX_STATUS, 8'h00);
        check("capture overflow flag", rd & 32'h1, 32'h1);
        $display("capture test done");
    endtask : t_capture

    task automatic t_envelope();
        apb(1'b1, IDX_CONTROL, 8'h00);
        apb(1'b1, IDX_STATUS, 8'h07);
        apb(1'b1, IDX_ENVELOPE_LOW, 8'hf0);
        apb(1'b1, IDX_ENVELOPE_HI, 8'h0f);
        apb(1'b1, IDX_CONTROL, 8'h83);
        @(posedge pclk);
        rx_half    <= 8'd4;
        rx_carrier <= 1'b1;
        cycles(50);
        apb(1'b0, IDX_STATUS, 8'h00);
        check("envelope found", rd & 32'h84, 32'h84);
        apb(1'b1, IDX_STATUS, 8'h07);
        cycles(40);
        apb(1'b0, IDX_STATUS, 8'h00);
        check("envelope held", rd & 32'h84, 32'h80);
        @(posedge pclk);
        rx_carrier <= 1'b0;
        cycles(40);
        apb(1'b0, IDX_STATUS, 8'h00);
        check("envelope lost", rd & 32'h84, 32'h04);
        apb(1'b1, IDX_SPECIAL_CFG, 8'h20);
        @(posedge pclk);
        rx_level <= 1'b1;
        cycles(3);
        apb(1'b0, IDX_STATUS, 8'h00);
        check("level present", rd & 32'h80, 32'h80);
        @(posedge pclk);
        rx_level <= 1'b0;
        cycles(3);
        apb(1'b0, IDX_STATUS, 8'h00);
        check("level absent", rd & 32'h80, 32'h0);
        $display("envelope test done");
    endtask : t_envelope

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_pwm();
        t_level();
        t_capture();
        t_envelope();
        close_out();
    end

    // whole run is near 4800 cycles; this is over twelve times that
    initial begin
        #600000;
        err_count++;
        close_out();
    end
endmodule : ir_carrier_timer_capture_envelope_tb
